/* File: src/imx_pkg.sv */
// Operation
// R1: First interpolation stage is a 67-tap half-band doubling the rate.
// R2: First stage taps are symmetric, centre 16384, outer taps as listed.
// R3: Second stage is a symmetric 19-tap half-band with centre 4096.
// R4: Third stage is a symmetric 11-tap half-band with centre 2048.
// R5: 4x cascades stages one and two; 8x cascades all three stages.
// R6: Optional inverse-sinc stage is a 9-tap filter at the output rate.
// R7: Phase accumulator adds the 32-bit frequency word every clock cycle.
// R8: The selected sync source clears the phase accumulator to zero.
// R9: A 16-bit phase offset is added before sine and cosine generation.
// R10: Mixer outputs I*cos - Q*sin on I and I*sin + Q*cos on Q.
// R11: Mixer output is scaled by two to the power of boost minus one.
// R12: I and Q are scaled by separate unsigned 11-bit gains, 0 to 2.
// R13: Signed 10-bit phase word times Q is added into the I path.
// R14: Sync select: 00 gate, 01 sync pin, 10 serial strobe, 11 zero.
// R15: Signed 13-bit offsets are added LSB aligned to I and Q.
// R16: Filter, mixer and correction arithmetic saturates to 16 bits.
// R17: Software backs the signal off before the inverse-sinc stage.
package imx_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_FREQ    = 8'h04;
   localparam logic [7:0]  REG_PHASE   = 8'h08;
   localparam logic [7:0]  REG_GAIN    = 8'h0C;
   localparam logic [7:0]  REG_QPHASE  = 8'h10;
   localparam logic [7:0]  REG_OFFSET  = 8'h14;
   localparam logic [7:0]  REG_SYNC    = 8'h18;
   localparam logic [7:0]  REG_STATUS  = 8'h1C;
   localparam int          CTRL_INTERP = 0;
   localparam int          CTRL_MIX_EN = 2;
   localparam int          CTRL_BOOST  = 3;
   localparam int          CTRL_ISINC  = 4;
   localparam int          CTRL_SYNC   = 5;
   localparam int          GAIN_B      = 16;
   localparam int          OFFSET_B    = 16;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] GAIN_RST    = 32'h0400_0400;
   localparam logic [1:0]  MODE_2X     = 2'h0;
   localparam logic [1:0]  MODE_4X     = 2'h1;
   typedef enum logic [1:0] {
      SYNC_GATE   = 2'h0,
      SYNC_PIN    = 2'h1,
      SYNC_SERIAL = 2'h2,
      SYNC_ZERO   = 2'h3
   } imx_sync_sel_t;
   // ***************************************************************
   // Filter coefficients, outermost tap in the lowest slot
   // ***************************************************************
   localparam logic [17*16-1:0] HB1_COEF = {
      16'h289B, 16'hF2D4, 16'h077C, 16'hFB14, 16'h036D, 16'hFD90,
      16'h01BC, 16'hFEC6, 16'h00DA, 16'hFF6C, 16'h0061, 16'h003D,
      16'h0025, 16'hFFEB, 16'h000B, 16'hFFFB, 16'h0002};
   localparam logic [5*16-1:0]  HB2_COEF = {
      16'h09D9, 16'hFD82, 16'h00D6, 16'hFFC6, 16'h0009};
   localparam logic [3*16-1:0]  HB3_COEF = {16'h04BC, 16'hFF25, 16'h001F};
   localparam logic [4*16-1:0]  ISINC_COEF = {16'hFFCE, 16'h000D, 16'hFFFC, 16'h0001};
   localparam logic [15:0]      HB1_CTR   = 16'h4000;
   localparam logic [15:0]      HB2_CTR   = 16'h1000;
   localparam logic [15:0]      HB3_CTR   = 16'h0800;
   localparam logic [15:0]      ISINC_CTR = 16'h0250;
   localparam int               ISINC_SHIFT = 9;
   localparam int               GAIN_SHIFT  = 10;
   localparam int               QPH_SHIFT   = 12;
   localparam int               CORDIC_N    = 14;
   localparam logic [14*16-1:0] ATAN = {
      16'h0001, 16'h0003, 16'h0005, 16'h000A, 16'h0014, 16'h0029, 16'h0051,
      16'h00A3, 16'h0146, 16'h028B, 16'h0511, 16'h09FB, 16'h12E4, 16'h2000};
   localparam logic signed [17:0] CORDIC_X0 = 18'sh0_4DBA;
   localparam logic signed [47:0] SAT_MAX   = 48'sh0000_0000_7FFF;
   localparam logic signed [47:0] SAT_MIN   = 48'shFFFF_FFFF_8000;

   function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
      if (v > SAT_MAX)
         return 16'sh7FFF;
      else if (v < SAT_MIN)
         return 16'sh8000;
      return v[15:0];
   endfunction

   // Rotation-mode CORDIC, returns {cos, sin} at about full scale.
   function automatic logic [31:0] cordic(input logic [15:0] ph);
      logic signed [17:0] x;
      logic signed [17:0] y;
      logic signed [17:0] z;
      logic signed [17:0] xt;
      logic signed [15:0] c;
      logic signed [15:0] s;
      x = CORDIC_X0;
      y = '0;
      z = $signed({4'h0, ph[13:0]});
      for (int i = 0; i < CORDIC_N; i++)
      begin
         xt = x;
         if (!z[17])
         begin
            x = x - (y >>> i);
            y = y + (xt >>> i);
            z = z - $signed({2'b00, ATAN[i*16+:16]});
         end
         else
         begin
            x = x + (y >>> i);
            y = y - (xt >>> i);
            z = z + $signed({2'b00, ATAN[i*16+:16]});
         end
      end
      c = sat16(48'(x));
      s = sat16(48'(y));
      unique case (ph[15:14])
         2'h0: return {c, s};
         2'h1: return {-s, c};
         2'h2: return {-c, -s};
         2'h3: return {s, -c};
      endcase
   endfunction
endpackage

/* File: src/imx_path.sv */
`timescale 1ns/100ps
`default_nettype none
// ******************************************************************
// Half-band interpolator for two channels, polyphase form
// ******************************************************************
module imx_halfband
   import imx_pkg::*;
#(
   parameter int              NT    = 17,
   parameter int              SHIFT = 14,
   parameter logic [NT*16-1:0] COEF = '0,
   parameter logic [15:0]     CTR   = 16'h4000
)(
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        bypass_i,
   input  wire logic        in_valid_i,
   input  wire logic [31:0] in_data_i,
   output logic             in_ready_o,
   output logic             out_valid_o,
   output logic [31:0]      out_data_o,
   input  wire logic        out_ready_i
);
   logic        phase_ff;
   logic [15:0] line_ff [2][2*NT];
   logic [31:0] sum_data;
   logic [31:0] ctr_data;
   logic        can_load;
   logic        accept;

   assign can_load   = !out_valid_o || out_ready_i;
   assign in_ready_o = can_load && (bypass_i || !phase_ff);
   assign accept     = in_valid_i && in_ready_o && !bypass_i;

   for (genvar ch = 0; ch < 2; ch++)
   begin : g_ch
      // R2 R3 R4 symmetric taps
      always_comb
      begin
         logic signed [47:0] acc;
         acc = '0;
         for (int k = 0; k < NT; k++)
            acc = acc + 48'($signed(COEF[k*16+:16]) *
                  ($signed({line_ff[ch][k][15], line_ff[ch][k]}) +
                   $signed({line_ff[ch][2*NT-1-k][15], line_ff[ch][2*NT-1-k]})));
         sum_data[ch*16+:16] = sat16(acc >>> SHIFT);
         ctr_data[ch*16+:16] = sat16(48'($signed(line_ff[ch][NT-1]) * $signed(CTR)) >>> SHIFT);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         line_ff <= '{default: '0};
      else if (accept)
         for (int ch = 0; ch < 2; ch++)
         begin
            line_ff[ch][0] <= in_data_i[ch*16+:16];
            for (int j = 1; j < 2*NT; j++)
               line_ff[ch][j] <= line_ff[ch][j-1];
         end
   end

   // R1 two outputs per input
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i || bypass_i)
         phase_ff <= 1'b0;
      else if (accept)
         phase_ff <= 1'b1;
      else if (phase_ff && can_load)
         phase_ff <= 1'b0;
   end

   // The centre term of the old line belongs before the new symmetric sum.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end
      else if (can_load)
      begin
         out_valid_o <= bypass_i ? in_valid_i : (phase_ff || in_valid_i);
         out_data_o  <= bypass_i ? in_data_i : (phase_ff ? sum_data : ctr_data);
      end
   end

   property p_hb_pair;
      @(posedge ref_clk_i) disable iff (srst_i)
      accept |=> out_valid_o && phase_ff;
   endproperty
   a_hb_pair: assert property (p_hb_pair) else $error("half-band missed output"); // R1
endmodule

// ******************************************************************
// Interpolation, mixer, correction and inverse-sinc path
// ******************************************************************
module imx_path
   import imx_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        src_valid_i,
   input  wire logic [15:0] src_i_data_i,
   input  wire logic [15:0] src_q_data_i,
   output logic             src_ready_o,
   input  wire logic        transmit_gate_i,
   input  wire logic        sync_pin_i,
   output logic             dac_valid_o,
   output logic [15:0]      dac_i_o,
   output logic [15:0]      dac_q_o,
   input  wire logic        dac_ready_i
);
   logic [31:0] ctrl_ff;
   logic [31:0] freq_ff;
   logic [15:0] poff_ff;
   logic [31:0] gain_ff;
   logic [9:0]  qphase_ff;
   logic [31:0] offset_ff;
   logic        serial_sync_strobe_ff;
   logic [31:0] acc_ff;
   logic [31:0] buf_ff [2];
   logic        wr_ptr_ff;
   logic        rd_ptr_ff;
   logic [1:0]  cnt_ff;
   logic        buf_pop;
   logic        wr_en;
   logic        sync_hit;
   logic [31:0] cs;
   logic        v1, v2, v3, r0, r1, r2, r3;
   logic [31:0] d1, d2, d3;
   logic        a_valid_ff;
   logic [15:0] a_i_ff, a_q_ff;
   logic        a_can, b_can, a_load, b_load;
   logic [15:0] nxt_a_i, nxt_a_q;
   logic [15:0] isinc_ff [2][8];
   logic [15:0] nxt_dac_i, nxt_dac_q;

   function automatic logic reg_mapped(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= REG_STATUS;
   endfunction

   // ***************************************************************
   // APB slave, zero wait states, read data captured in setup
   // ***************************************************************
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !reg_mapped(paddr_i);
   assign wr_en     = psel_i && penable_i && pwrite_i && reg_mapped(paddr_i);

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         ctrl_ff   <= CTRL_RST;
         freq_ff   <= '0;
         poff_ff   <= '0;
         gain_ff   <= GAIN_RST;
         qphase_ff <= '0;
         offset_ff <= '0;
      end
      else if (wr_en)
         unique case (paddr_i)
            REG_CTRL:   ctrl_ff   <= pwdata_i;
            REG_FREQ:   freq_ff   <= pwdata_i;
            REG_PHASE:  poff_ff   <= pwdata_i[15:0];
            REG_GAIN:   gain_ff   <= pwdata_i;
            REG_QPHASE: qphase_ff <= pwdata_i[9:0];
            REG_OFFSET: offset_ff <= pwdata_i;
            default:    ;
         endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         serial_sync_strobe_ff <= 1'b0;
      else
         serial_sync_strobe_ff <= wr_en && paddr_i == REG_SYNC && pwdata_i[0];
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         prdata_o <= '0;
      else if (psel_i && !penable_i)
         unique case (paddr_i)
            REG_CTRL:   prdata_o <= {25'h0, ctrl_ff[6:0]};
            REG_FREQ:   prdata_o <= freq_ff;
            REG_PHASE:  prdata_o <= {16'h0, poff_ff};
            REG_GAIN:   prdata_o <= {5'h0, gain_ff[26:16], 5'h0, gain_ff[10:0]};
            REG_QPHASE: prdata_o <= {22'h0, qphase_ff};
            REG_OFFSET: prdata_o <= {3'h0, offset_ff[28:16], 3'h0, offset_ff[12:0]};
            REG_STATUS: prdata_o <= {14'h0, cnt_ff, acc_ff[31:16]};
            default:    prdata_o <= '0;
         endcase
   end

   // ***************************************************************
   // Two-entry input buffer
   // ***************************************************************
   assign src_ready_o = cnt_ff != 2'd2;
   assign buf_pop     = cnt_ff != 2'd0 && r1;

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         buf_ff    <= '{default: '0};
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= '0;
      end
      else
      begin
         if (src_valid_i && src_ready_o)
         begin
            buf_ff[wr_ptr_ff] <= {src_q_data_i, src_i_data_i};
            wr_ptr_ff         <= !wr_ptr_ff;
         end
         if (buf_pop)
            rd_ptr_ff <= !rd_ptr_ff;
         cnt_ff <= cnt_ff + 2'(src_valid_i && src_ready_o) - 2'(buf_pop);
      end
   end

   // ***************************************************************
   // Interpolation cascade
   // ***************************************************************
   // R5 stage selection by mode
   imx_halfband #(.NT(17), .SHIFT(14), .COEF(HB1_COEF), .CTR(HB1_CTR)) u_halfband_stage_one (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .bypass_i    (1'b0),
      .in_valid_i  (cnt_ff != 2'd0),
      .in_data_i   (buf_ff[rd_ptr_ff]),
      .in_ready_o  (r1),
      .out_valid_o (v1),
      .out_data_o  (d1),
      .out_ready_i (r2)
   );
   imx_halfband #(.NT(5), .SHIFT(12), .COEF(HB2_COEF), .CTR(HB2_CTR)) u_halfband_stage_two (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .bypass_i    (ctrl_ff[CTRL_INTERP+:2] == MODE_2X),
      .in_valid_i  (v1),
      .in_data_i   (d1),
      .in_ready_o  (r2),
      .out_valid_o (v2),
      .out_data_o  (d2),
      .out_ready_i (r3)
   );
   imx_halfband #(.NT(3), .SHIFT(11), .COEF(HB3_COEF), .CTR(HB3_CTR)) u_halfband_stage_three (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .bypass_i    (ctrl_ff[CTRL_INTERP+:2] == MODE_2X || ctrl_ff[CTRL_INTERP+:2] == MODE_4X),
      .in_valid_i  (v2),
      .in_data_i   (d2),
      .in_ready_o  (r3),
      .out_valid_o (v3),
      .out_data_o  (d3),
      .out_ready_i (r0)
   );

   // ***************************************************************
   // Oscillator and complex mixer
   // ***************************************************************
   // R14 sync source select
   always_comb
   begin
      unique case (imx_sync_sel_t'(ctrl_ff[CTRL_SYNC+:2]))
         SYNC_GATE:   sync_hit = transmit_gate_i;
         SYNC_PIN:    sync_hit = sync_pin_i;
         SYNC_SERIAL: sync_hit = serial_sync_strobe_ff;
         SYNC_ZERO:   sync_hit = 1'b0;
      endcase
   end

   // R7 R8 accumulate or clear
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i || sync_hit)
         acc_ff <= '0;
      else
         acc_ff <= acc_ff + freq_ff;
   end

   // R9 phase offset before sine lookup
   assign cs    = cordic(acc_ff[31:16] + poff_ff);
   assign a_can = !a_valid_ff || b_can;
   assign r0    = a_can;
   assign a_load = v3 && a_can;

   // The clip comes ahead of the gain, so boost 1 clips the mixer output near full scale before any gain.
   always_comb
   begin
      logic signed [47:0] mi;
      logic signed [47:0] mq;
      mi = 48'($signed(d3[15:0]));
      mq = 48'($signed(d3[31:16]));
      if (ctrl_ff[CTRL_MIX_EN])
      begin
         // R10 R11 rotate and scale
         mi = 48'($signed(d3[15:0]) * $signed(cs[31:16]) - $signed(d3[31:16]) * $signed(cs[15:0]));
         mq = 48'($signed(d3[15:0]) * $signed(cs[15:0]) + $signed(d3[31:16]) * $signed(cs[31:16]));
         mi = 48'(sat16(mi >>> (ctrl_ff[CTRL_BOOST] ? 15 : 16)));
         mq = 48'(sat16(mq >>> (ctrl_ff[CTRL_BOOST] ? 15 : 16)));
      end
      // R12 R13 R16 gain and phase correction
      nxt_a_i = sat16((48'(mi * $signed({1'b0, gain_ff[10:0]})) >>> GAIN_SHIFT)
                + (48'(mq * $signed(qphase_ff)) >>> QPH_SHIFT));
      nxt_a_q = sat16(48'(mq * $signed({1'b0, gain_ff[GAIN_B+:11]})) >>> GAIN_SHIFT);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         a_valid_ff <= 1'b0;
         a_i_ff     <= '0;
         a_q_ff     <= '0;
      end
      else if (a_can)
      begin
         a_valid_ff <= v3;
         a_i_ff     <= nxt_a_i;
         a_q_ff     <= nxt_a_q;
      end
   end

   // ***************************************************************
   // Inverse sinc and offset
   // ***************************************************************
   assign b_can  = !dac_valid_o || dac_ready_i;
   assign b_load = a_valid_ff && b_can;

   always_comb
   begin
      logic signed [47:0] acc;
      logic signed [15:0] w [2][9];
      logic signed [47:0] res [2];
      acc = '0;
      w = '{default: '0};
      res = '{default: '0};
      for (int ch = 0; ch < 2; ch++)
      begin
         w[ch][0] = ch == 0 ? a_i_ff : a_q_ff;
         for (int j = 1; j < 9; j++)
            w[ch][j] = isinc_ff[ch][j-1];
         // R6 nine-tap symmetric sum
         acc = 48'(w[ch][4] * $signed(ISINC_CTR));
         for (int k = 0; k < 4; k++)
            acc = acc + 48'($signed(ISINC_COEF[k*16+:16]) * (17'(w[ch][k]) + 17'(w[ch][8-k])));
         res[ch] = ctrl_ff[CTRL_ISINC] ? 48'(sat16(acc >>> ISINC_SHIFT)) : 48'(w[ch][0]);
      end
      // R15 offsets added LSB aligned
      nxt_dac_i = sat16(res[0] + 48'($signed(offset_ff[12:0])));
      nxt_dac_q = sat16(res[1] + 48'($signed(offset_ff[OFFSET_B+:13])));
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         isinc_ff <= '{default: '0};
      else if (b_load)
         for (int ch = 0; ch < 2; ch++)
         begin
            isinc_ff[ch][0] <= ch == 0 ? a_i_ff : a_q_ff;
            for (int j = 1; j < 8; j++)
               isinc_ff[ch][j] <= isinc_ff[ch][j-1];
         end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         dac_valid_o <= 1'b0;
         dac_i_o     <= '0;
         dac_q_o     <= '0;
      end
      else if (b_can)
      begin
         dac_valid_o <= a_valid_ff;
         dac_i_o     <= nxt_dac_i;
         dac_q_o     <= nxt_dac_q;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_acc_step;
      @(posedge ref_clk_i) disable iff (srst_i)
      !sync_hit |=> acc_ff == $past(acc_ff) + $past(freq_ff);
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // R7

   property p_sync_clear;
      @(posedge ref_clk_i) disable iff (srst_i)
      sync_hit |=> acc_ff == 32'h0000_0000;
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear"); // R8

   property p_sync_zero;
      @(posedge ref_clk_i) disable iff (srst_i)
      ctrl_ff[CTRL_SYNC+:2] == SYNC_ZERO && transmit_gate_i && sync_pin_i |-> !sync_hit;
   endproperty
   a_sync_zero: assert property (p_sync_zero) else $error("zero source fired"); // R14

   property p_unity_gain;
      @(posedge ref_clk_i) disable iff (srst_i)
      a_load && !ctrl_ff[CTRL_MIX_EN] && gain_ff == GAIN_RST && qphase_ff == 10'h000
      |=> a_i_ff == $past(d3[15:0]) && a_q_ff == $past(d3[31:16]);
   endproperty
   a_unity_gain: assert property (p_unity_gain) else $error("unity gain altered data"); // R12

   property p_offset;
      @(posedge ref_clk_i) disable iff (srst_i)
      b_load && !ctrl_ff[CTRL_ISINC] && offset_ff == 32'h0000_0000
      |=> dac_i_o == $past(a_i_ff) && dac_q_o == $past(a_q_ff);
   endproperty
   a_offset: assert property (p_offset) else $error("zero offset altered data"); // R15
   property p_offset_sat;
      @(posedge ref_clk_i) disable iff (srst_i)
      b_load && !ctrl_ff[CTRL_ISINC] && offset_ff[12:0] == 13'h0FFF && a_i_ff == 16'h7FFF
      |=> dac_i_o == 16'h7FFF;
   endproperty
   a_offset_sat: assert property (p_offset_sat) else $error("offset wrapped"); // R16

   property p_dac_hold;
      @(posedge ref_clk_i) disable iff (srst_i)
      dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_i_o) && $stable(dac_q_o);
   endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("output dropped under stall");

   property p_buf_count;
      @(posedge ref_clk_i) disable iff (srst_i)
      src_valid_i && src_ready_o && !buf_pop |=> cnt_ff == $past(cnt_ff) + 2'd1;
   endproperty
   a_buf_count: assert property (p_buf_count) else $error("buffer lost a word");
endmodule
`default_nettype wire

/* File: verif/imx_stream_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************
// Input buffer source and converter sink
// ********************
module imx_stream_model
(
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic [15:0] val_i_i,
   input  wire logic [15:0] val_q_i,
   input  wire logic [31:0] budget_i,
   input  wire logic        src_ready_i,
   input  wire logic        dac_valid_i,
   input  wire logic [15:0] dac_i_i,
   input  wire logic [15:0] dac_q_i,
   output logic             src_valid_o,
   output logic [15:0]      src_i_o,
   output logic [15:0]      src_q_o,
   output logic             dac_ready_o,
   output logic [31:0]      sent_o,
   output logic [31:0]      got_o,
   output logic [15:0]      last_i_o,
   output logic [15:0]      last_q_o,
   output logic             full_o
);
   int   seed = 32'h372a;
   logic go_ff;
   assign src_valid_o = !srst_i && (sent_o < budget_i);
   // Idle data lines show the inverse, so a stale word never passes for a fresh one.
   assign src_i_o = src_valid_o ? val_i_i : ~val_i_i;
   assign src_q_o = src_valid_o ? val_q_i : ~val_q_i;
   // The sink stalls about one cycle in four, which backs words up into the buffer.
   assign dac_ready_o = go_ff && !srst_i;
   always_ff @(posedge clk_i)
   begin
      go_ff <= ($random(seed) & 3) != 0;
      if (srst_i)
      begin
         sent_o <= '0;
         got_o  <= '0;
         full_o <= 1'b0;
      end
      else
      begin
         if (src_valid_o && src_ready_i)
            sent_o <= sent_o + 1;
         if (dac_valid_i && dac_ready_o)
         begin
            got_o    <= got_o + 1;
            last_i_o <= dac_i_i;
            last_q_o <= dac_q_i;
         end
         if (src_valid_o && !src_ready_i)
            full_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: verif/interp_mixer_iq_correction_path_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************
// Bench top
// ********************
module interp_mixer_iq_correction_path_tb_top;
   import imx_pkg::*;
   localparam int LIMIT = 40000;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        gate = 1'b0;
   logic        pin = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] budget = 32'h0000_0000;
   logic [15:0] val_i = 16'h0000;
   logic [15:0] val_q = 16'h0000;
   logic [31:0] prdata, rd, sent, got;
   logic [15:0] src_i, src_q, dac_i, dac_q, last_i, last_q, acc0;
   logic        pready, pslverr, err, src_valid, src_ready, dac_valid, dac_ready, full;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          seed = 32'h372a;
   int          k, g0;

   always #2 clk = ~clk;

   imx_path dut (.ref_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .src_valid_i(src_valid),
      .src_i_data_i(src_i), .src_q_data_i(src_q), .src_ready_o(src_ready),
      .transmit_gate_i(gate), .sync_pin_i(pin), .dac_valid_o(dac_valid),
      .dac_i_o(dac_i), .dac_q_o(dac_q), .dac_ready_i(dac_ready));
   imx_stream_model model (.clk_i(clk), .srst_i(srst), .val_i_i(val_i), .val_q_i(val_q),
      .budget_i(budget), .src_ready_i(src_ready), .dac_valid_i(dac_valid), .dac_i_i(dac_i),
      .dac_q_i(dac_q), .src_valid_o(src_valid), .src_i_o(src_i), .src_q_o(src_q),
      .dac_ready_o(dac_ready), .sent_o(sent), .got_o(got), .last_i_o(last_i),
      .last_q_o(last_q), .full_o(full));

   task print_verdict;
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic int sat(input int v);
      return (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
   endfunction

   function automatic int corr(input int x, input int y, input int g, input int qp);
      return sat(((x * g) >>> 10) + ((y * qp) >>> 12));
   endfunction

   // Settle on one input, then judge the last word.
   task dc(input logic [31:0] ctrl, input logic [31:0] gain, input logic [31:0] qph,
      input logic [31:0] off, input logic [31:0] ph, input int i, input int q,
      input int ei, input int eq, input int tol);
      int n, di, dq;
      val_i <= 16'(i);
      val_q <= 16'(q);
      budget <= 32'hFFFF_FFFF;
      apb(1'b1, REG_CTRL, ctrl);
      apb(1'b1, REG_GAIN, gain);
      apb(1'b1, REG_QPHASE, qph);
      apb(1'b1, REG_OFFSET, off);
      apb(1'b1, REG_PHASE, ph);
      n = got + 400;
      wait (got >= n);
      di = $signed(last_i) - ei;
      dq = $signed(last_q) - eq;
      check("dac_i", {31'd0, di <= tol && di >= -tol}, 32'd1);
      check("dac_q", {31'd0, dq <= tol && dq >= -tol}, 32'd1);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_errors++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl_reset", rd, CTRL_RST);
      apb(1'b0, REG_GAIN, 32'h0);
      check("gain_reset", rd, GAIN_RST);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      k = $random(seed);
      apb(1'b1, REG_PHASE, 32'(k));
      apb(1'b0, REG_PHASE, 32'h0);
      check("phase_rw", rd, {16'h0000, 16'(k)});
      apb(1'b1, REG_FREQ, 32'h0001_0000);
      apb(1'b1, REG_CTRL, 32'h0000_0060);
      apb(1'b0, REG_STATUS, 32'h0);
      acc0 = rd[15:0];
      apb(1'b0, REG_STATUS, 32'h0);
      check("nco_step", {16'h0, rd[15:0] - acc0}, 32'd3);
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, REG_CTRL, 32'(s) << 5);
         repeat (60) @(posedge clk);
         gate <= (s == 0) || (s == 3);
         pin <= (s == 1) || (s == 3);
         if (s == 2)
            apb(1'b1, REG_SYNC, 32'h1);
         @(posedge clk);
         gate <= 1'b0;
         pin <= 1'b0;
         apb(1'b0, REG_STATUS, 32'h0);
         check("nco_sync", {31'd0, rd[15:0] < 16'd20}, 32'(s != 3));
      end
      apb(1'b1, REG_FREQ, 32'h0);
      apb(1'b1, REG_CTRL, 32'h40);
      apb(1'b1, REG_SYNC, 32'h1);
      dc(32'h40, GAIN_RST, 0, 0, 0, 1000, -2000, 1000, -2000, 30);
      dc(32'h41, 32'h07FF_0200, 0, 0, 0, 4000, 4000, corr(4000, 0, 512, 0),
         corr(4000, 0, 2047, 0), 140);
      dc(32'h42, GAIN_RST, 0, 32'h1000_0FFF, 0, 32767, -32768, sat(32767 + 4095),
         sat(-32768 - 4096), 0);
      dc(32'h40, GAIN_RST, 32'h100, 0, 0, 1000, 8000, corr(1000, 8000, 1024, 256),
         8000, 150);
      dc(32'h4C, GAIN_RST, 0, 0, 32'h4000, 3000, 1000, -1000, 3000, 100);
      dc(32'h44, GAIN_RST, 0, 0, 0, 3000, 1000, 1500, 500, 60);
      dc(32'h50, 32'h0200_0200, 0, 0, 0, 6000, -6000, corr(6000, 0, 512, 0),
         corr(-6000, 0, 512, 0), 80);
      for (int m = 0; m < 4; m++)
      begin
         budget <= sent;
         repeat (300) @(posedge clk);
         apb(1'b1, REG_CTRL, 32'h40 | 32'(m));
         g0 = got;
         k = (5 + ($random(seed) & 15)) * ((m == 0) ? 2 : (m == 1) ? 4 : 8);
         val_i <= 16'($random(seed));
         val_q <= 16'($random(seed));
         budget <= sent + 32'(k / ((m == 0) ? 2 : (m == 1) ? 4 : 8));
         wait (got == 32'(g0 + k));
         repeat (100) @(posedge clk);
         check("ratio", got - 32'(g0), 32'(k));
      end
      check("buffer_full", {31'd0, full}, 32'd1);
      print_verdict();
   end
endmodule
`default_nettype wire
